// ### shared/vic_defines.svh
// Constants of the vectored interrupt controller fast path
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH
`define VIC_NSRC        32
`define VIC_NUM_W       5
`define VIC_PRIO_W      3
`define VIC_DATA_W      32
`define VIC_STACK_DEPTH 8
`define VIC_STACK_PTR_W 4
`define VIC_STACK_IDX_W 3
`define VIC_FAST_SRC    0
`define VIC_RST_MASK    32'h0000_0000
`define VIC_RST_FORCE   32'h0000_0000
`define VIC_RST_VECTOR  32'h0000_0000
`define VIC_RST_NUM     5'h00
`define VIC_RST_PTR     4'h0
`endif

// ### shared/vic_pkg.sv
// Types of the vectored interrupt controller fast path
package vic_pkg;
`include "vic_defines.svh"

    typedef struct packed {
        logic [`VIC_NSRC-1:0]                   edge_mode;
        logic [`VIC_NSRC-1:0]                   pol_high;
        logic [`VIC_NSRC-1:0][`VIC_PRIO_W-1:0]  prio;
        logic [`VIC_NSRC-1:0][`VIC_DATA_W-1:0]  vector_slot;
        logic [`VIC_DATA_W-1:0]                 spurious_vector_reg;
        logic                                   debug_protect_bit;
        logic                                   general_mask_bit;
    } vic_cfg_t;

    typedef struct packed {
        logic                   enable_cmd_reg;
        logic                   disable_cmd_reg;
        logic                   clear_cmd_reg;
        logic                   force_enable_cmd;
        logic                   force_disable_cmd;
        logic                   end_of_irq_cmd;
        logic                   normal_vector_wr;
        logic                   normal_vector_rd;
        logic                   fast_vector_rd;
        logic [`VIC_DATA_W-1:0] data;
    } vic_cmd_t;

    typedef struct packed {
        logic [`VIC_NSRC-1:0]   pending_reg;
        logic [`VIC_NSRC-1:0]   mask_reg;
        logic [`VIC_NSRC-1:0]   force_status_reg;
        logic [`VIC_NUM_W-1:0]  current_irq_status;
        logic [`VIC_DATA_W-1:0] normal_vector_reg;
        logic [`VIC_DATA_W-1:0] fast_vector_reg;
    } vic_status_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic edge_pend;
    } vic_det_state_t;

    typedef struct packed {
        logic [`VIC_NSRC-1:0]                          mask;
        logic [`VIC_NSRC-1:0]                          force_en;
        logic [`VIC_STACK_PTR_W-1:0]                   depth;
        logic [`VIC_STACK_DEPTH-1:0][`VIC_PRIO_W-1:0]  lvl;
        logic [`VIC_STACK_DEPTH-1:0][`VIC_NUM_W-1:0]   num;
        logic [`VIC_NUM_W-1:0]                         isr;
        logic [`VIC_NUM_W-1:0]                         held_num;
        logic [`VIC_PRIO_W-1:0]                        held_lvl;
        logic                                          held_valid;
        logic [`VIC_DATA_W-1:0]                        ivr_data;
        logic [`VIC_DATA_W-1:0]                        fvr_data;
    } vic_state_t;
endpackage

// ### core/vic_src_detect.sv
// Per-source synchroniser, edge detector and pending flag
`timescale 1ns/1ps
module vic_src_detect (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic src_pin,
    input  wire logic edge_mode,
    input  wire logic pol_high,
    input  wire logic clr,
    output logic      pending
);
    import vic_pkg::*;

    vic_det_state_t state_reg;
    vic_det_state_t state_next;
    logic           edge_hit;

    // ==========================================================
    // Detection
    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = src_pin;
        state_next.sync2 = state_reg.sync1;
        state_next.prev  = state_reg.sync2;
        edge_hit = (state_reg.sync2 == pol_high) && (state_reg.prev != pol_high);
        // Set wins over clear
        state_next.edge_pend = edge_hit | (state_reg.edge_pend & ~clr);
    end

    assign pending = edge_mode ? state_reg.edge_pend : (state_reg.sync2 == pol_high);

    // ==========================================================
    // Registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ### core/vectored_irq_ctrl.sv
// Fast interrupt path, fast forcing, protect mode and general mask
// Operation
// (RL1) Fast vector read returns source 0 vector slot, whatever source fired.
// (RL2) Fast vector read clears edge source 0; level source 0 untouched.
// (RL3) Software removes level source 0 cause at the peripheral.
// (RL4) Force enable/disable commands set/clear bits of force status register.
// (RL5) Forced source keeps detection but never reaches normal request or priority.
// (RL6) Forced source with active level or edge asserts fast request.
// (RL7) Forcing leaves source 0 pending bit unchanged.
// (RL8) While forcing in use, fast vector read does no auto clear.
// (RL9) Software clears forced edge sources through clear command.
// (RL10) Normal vector read never clears a forced source.
// (RL11) Source 0 still drives fast request while forcing is active.
// (RL12) Debug-protect bit set selects protect mode, cleared selects normal.
// (RL13) Normal read resolves, returns vector, records, pushes level, acknowledges.
// (RL14) Protect read resolves, returns, records; write pushes and acknowledges.
// (RL15) Protect read alone leaves context and status; write updates status.
// (RL16) Protect mode software writes vector register right after reading.
// (RL17) Normal mode vector register write has no effect.
// (RL18) Read with nothing pending returns spurious vector register.
// (RL19) Software loads spurious handler that writes end-of-interrupt.
// (RL20) General mask holds both request lines inactive.
// (RL21) General mask does not block the wake-up indication.
// (RL22) Enable/disable bit 0 controls fast source; mask bit 0 shows it.
// (RL23) Fast request from enabled source 0 or active forced source, unless masked.
`timescale 1ns/1ps
`include "vic_defines.svh"
module vectored_irq_ctrl (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic [`VIC_NSRC-1:0]   src_in,
    input  wire vic_pkg::vic_cfg_t      cfg,
    input  wire vic_pkg::vic_cmd_t      cmd,
    output vic_pkg::vic_status_t        status,
    output logic                        normal_req_n,
    output logic                        fast_req_n,
    output logic                        wake_up
);
    import vic_pkg::*;

    vic_state_t                    state_reg;
    vic_state_t                    state_next;
    logic [`VIC_NSRC-1:0]          pending;
    logic [`VIC_NSRC-1:0]          clr;
    logic [`VIC_NSRC-1:0]          eligible;
    logic                          found;
    logic                          higher;
    logic [`VIC_NUM_W-1:0]         best_num;
    logic [`VIC_PRIO_W-1:0]        best_lvl;
    logic [`VIC_PRIO_W-1:0]        cur_lvl;
    logic [`VIC_STACK_IDX_W-1:0]   top;
    logic                          ack;
    logic [`VIC_NUM_W-1:0]         ack_num;
    logic [`VIC_PRIO_W-1:0]        ack_lvl;
    logic                          fast_any;
    logic                          normal_any;

    // ==========================================================
    // Source detectors
    genvar g;
    generate
        for (g = 0; g < `VIC_NSRC; g++) begin : gen_src
            vic_src_detect u_det (
                .mclk      (mclk),
                .resetn    (resetn),
                .src_pin   (src_in[g]),
                .edge_mode (cfg.edge_mode[g]),
                .pol_high  (cfg.pol_high[g]),
                .clr       (clr[g]),
                .pending   (pending[g])
            );
        end
    endgenerate

    // ==========================================================
    // Priority resolution
    always_comb begin
        top      = state_reg.depth[`VIC_STACK_IDX_W-1:0] - 3'h1;
        cur_lvl  = state_reg.lvl[top];
        eligible = pending & state_reg.mask & ~state_reg.force_en; // RL5
        eligible[`VIC_FAST_SRC] = 1'b0;
        found    = 1'b0;
        best_num = `VIC_RST_NUM;
        best_lvl = '0;
        for (int i = 1; i < `VIC_NSRC; i++) begin
            if (eligible[i] && (!found || cfg.prio[i] > best_lvl)) begin
                found    = 1'b1;
                best_num = `VIC_NUM_W'(i);
                best_lvl = cfg.prio[i];
            end
        end
        higher = found && ((state_reg.depth == `VIC_RST_PTR) || (best_lvl > cur_lvl));
    end

    // ==========================================================
    // Request lines
    always_comb begin
        // RL11 RL6 RL23
        fast_any = (pending[`VIC_FAST_SRC] & state_reg.mask[`VIC_FAST_SRC])
                 | (|(pending & state_reg.mask & state_reg.force_en));
        normal_any   = higher;
        fast_req_n   = ~(fast_any & ~cfg.general_mask_bit); // RL20
        normal_req_n = ~(normal_any & ~cfg.general_mask_bit); // RL20
        wake_up      = |(pending & state_reg.mask); // RL21
    end

    // ==========================================================
    // Acknowledge and clears
    always_comb begin
        ack     = 1'b0;
        ack_num = best_num;
        ack_lvl = best_lvl;
        if (cmd.normal_vector_rd && !cfg.debug_protect_bit && higher) begin
            ack = 1'b1; // RL13
        end else if (cmd.normal_vector_wr && cfg.debug_protect_bit && state_reg.held_valid) begin
            ack     = 1'b1; // RL14 RL17
            ack_num = state_reg.held_num;
            ack_lvl = state_reg.held_lvl;
        end
        clr = cmd.clear_cmd_reg ? cmd.data : '0;
        // Held number may have been forced since the protect read
        if (ack && cfg.edge_mode[ack_num] && !state_reg.force_en[ack_num]) begin
            clr[ack_num] = 1'b1; // RL10
        end
        // RL2 RL8
        if (cmd.fast_vector_rd && cfg.edge_mode[`VIC_FAST_SRC] && (state_reg.force_en == '0)) begin
            clr[`VIC_FAST_SRC] = 1'b1;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        if (cmd.enable_cmd_reg) begin
            state_next.mask = state_next.mask | cmd.data; // RL22
        end
        if (cmd.disable_cmd_reg) begin
            state_next.mask = state_next.mask & ~cmd.data; // RL22
        end
        if (cmd.force_enable_cmd) begin
            state_next.force_en = state_next.force_en | cmd.data; // RL4
        end
        if (cmd.force_disable_cmd) begin
            state_next.force_en = state_next.force_en & ~cmd.data; // RL4
        end
        state_next.force_en[`VIC_FAST_SRC] = 1'b0; // RL7
        if (cmd.fast_vector_rd) begin
            state_next.fvr_data = cfg.vector_slot[`VIC_FAST_SRC]; // RL1
        end
        if (cmd.normal_vector_rd) begin
            // RL18
            state_next.ivr_data = higher ? cfg.vector_slot[best_num] : cfg.spurious_vector_reg;
            if (cfg.debug_protect_bit) begin
                // RL15
                state_next.held_valid = higher;
                state_next.held_num   = best_num;
                state_next.held_lvl   = best_lvl;
            end
        end
        if (cmd.end_of_irq_cmd && state_reg.depth != `VIC_RST_PTR) begin
            state_next.depth = state_reg.depth - 4'h1;
            state_next.isr   = (state_reg.depth == 4'h1) ? `VIC_RST_NUM
                             : state_reg.num[top - 3'h1];
        end
        if (ack && state_reg.depth != `VIC_STACK_PTR_W'(`VIC_STACK_DEPTH)) begin
            // RL13 RL14
            state_next.lvl[state_reg.depth[`VIC_STACK_IDX_W-1:0]] = ack_lvl;
            state_next.num[state_reg.depth[`VIC_STACK_IDX_W-1:0]] = ack_num;
            state_next.depth = state_reg.depth + 4'h1;
            state_next.isr   = ack_num; // RL15
        end
        if (cmd.normal_vector_wr && cfg.debug_protect_bit) begin
            state_next.held_valid = 1'b0;
        end
        if (!cfg.debug_protect_bit) begin
            state_next.held_valid = 1'b0; // RL12
        end
    end

    // ==========================================================
    // Status
    always_comb begin
        status.pending_reg        = pending;
        status.mask_reg           = state_reg.mask;
        status.force_status_reg   = state_reg.force_en;
        status.current_irq_status = state_reg.isr;
        status.normal_vector_reg  = state_reg.ivr_data;
        status.fast_vector_reg    = state_reg.fvr_data;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg          <= '0;
            state_reg.mask     <= `VIC_RST_MASK;
            state_reg.force_en <= `VIC_RST_FORCE;
            state_reg.ivr_data <= `VIC_RST_VECTOR;
            state_reg.fvr_data <= `VIC_RST_VECTOR;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ### test/vic_ctrl_props.sv
// Checker of the fast interrupt path
`timescale 1ns/1ps
`include "vic_defines.svh"
module vic_ctrl_props
    import vic_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic [`VIC_NSRC-1:0] src_in,
    input wire vic_pkg::vic_cfg_t    cfg,
    input wire vic_pkg::vic_cmd_t    cmd,
    input wire vic_pkg::vic_status_t status,
    input wire logic                 normal_req_n,
    input wire logic                 fast_req_n,
    input wire logic                 wake_up
);
    wire [31:0] pnd = status.pending_reg;
    wire [31:0] msk = status.mask_reg;
    wire [31:0] frc = status.force_status_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ==========
    // Assertions
    chk_mask_both: assert property (cfg.general_mask_bit |-> fast_req_n && normal_req_n)
        else $error("request active under general mask");
    chk_fvr_slot: assert property (cmd.fast_vector_rd |=>
        status.fast_vector_reg == $past(cfg.vector_slot[0])) else $error("fast vector wrong");
    chk_force_set: assert property (cmd.force_enable_cmd && !cmd.force_disable_cmd |=>
        (~frc & $past(cmd.data) & 32'hffff_fffe) == 0) else $error("force bit not set");
    chk_force_clr: assert property (cmd.force_disable_cmd |=>
        (frc & $past(cmd.data)) == 0) else $error("force bit not cleared");
    chk_fast_clr: assert property (cmd.fast_vector_rd && cfg.edge_mode[0] && frc == 0 |=>
        !pnd[0]) else $error("fast edge source not cleared");
    chk_forced_kept: assert property (cmd.fast_vector_rd && !cmd.clear_cmd_reg |=>
        ($past(frc & pnd & cfg.edge_mode) & ~pnd) == 0) else $error("forced source cleared");
    chk_normal_gate: assert property ((pnd & msk & ~frc & 32'hffff_fffe) == 0 |->
        normal_req_n) else $error("normal request without source");
    chk_force_fast: assert property ((pnd & msk & frc) != 0 && !cfg.general_mask_bit |->
        !fast_req_n) else $error("forced source missing on fast line");
    chk_protect_rd: assert property (cfg.debug_protect_bit && cmd.normal_vector_rd &&
        !cmd.normal_vector_wr && !cmd.end_of_irq_cmd |=> $stable(status.current_irq_status))
        else $error("protect read changed status");
    chk_ivr_spurious: assert property (cmd.normal_vector_rd &&
        (pnd & msk & ~frc & 32'hffff_fffe) == 0 |=>
        status.normal_vector_reg == $past(cfg.spurious_vector_reg))
        else $error("spurious vector wrong");
    chk_mask_set: assert property (cmd.enable_cmd_reg && !cmd.disable_cmd_reg |=>
        (~msk & $past(cmd.data)) == 0) else $error("mask bit not set");
    cover property (cmd.fast_vector_rd && frc != 0);
    cover property (cmd.normal_vector_wr && cfg.debug_protect_bit);
    cover property (cfg.general_mask_bit && wake_up);
endmodule
bind vectored_irq_ctrl vic_ctrl_props u_props (.mclk(mclk), .resetn(resetn), .src_in(src_in),
    .cfg(cfg), .cmd(cmd), .status(status), .normal_req_n(normal_req_n),
    .fast_req_n(fast_req_n), .wake_up(wake_up));

// ### test/vic_core_model.sv
// Core model counting request assertions
`timescale 1ns/1ps
module vic_core_model (
    input wire logic   mclk,
    input wire logic   normal_req_n,
    input wire logic   fast_req_n,
    output logic [7:0] fast_seen,
    output logic [7:0] normal_seen
);
    logic fast_d = 1'b1;
    logic norm_d = 1'b1;
    initial fast_seen = 8'h00;
    initial normal_seen = 8'h00;
    always @(posedge mclk) begin
        if (!fast_req_n && fast_d) fast_seen <= fast_seen + 8'h01;
        if (!normal_req_n && norm_d) normal_seen <= normal_seen + 8'h01;
        fast_d <= fast_req_n;
        norm_d <= normal_req_n;
    end
endmodule

// ### test/fast_irq_forcing_protect_logic_bench.sv
// Self-checking bench of the fast interrupt path
`timescale 1ns/1ps
`include "vic_defines.svh"
module fast_irq_forcing_protect_logic_bench;
    import vic_pkg::*;
    logic                 mclk;
    logic                 resetn;
    logic [`VIC_NSRC-1:0] src_in;
    vic_cfg_t             cfg;
    vic_cmd_t             cmd;
    vic_status_t          status;
    logic                 normal_req_n;
    logic                 fast_req_n;
    logic                 wake_up;
    logic [7:0]           fast_seen;
    logic [7:0]           normal_seen;
    logic [31:0]          seed;
    logic [31:0]          exp_q[$];
    logic                 rd_d;
    logic                 rd_f;
    int                   num_errors = 0;
    int                   total_checks = 0;
    localparam logic [8:0] C_EN = 9'h100, C_CLR = 9'h040, C_FEN = 9'h020, C_FDIS = 9'h010;
    localparam logic [8:0] C_EOI = 9'h008, C_NWR = 9'h004;
    vectored_irq_ctrl u_dut (.mclk(mclk), .resetn(resetn), .src_in(src_in), .cfg(cfg),
        .cmd(cmd), .status(status), .normal_req_n(normal_req_n), .fast_req_n(fast_req_n),
        .wake_up(wake_up));
    vic_core_model u_core (.mclk(mclk), .normal_req_n(normal_req_n), .fast_req_n(fast_req_n),
        .fast_seen(fast_seen), .normal_seen(normal_seen));
    // ==========
    // Tasks
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic issue(input logic [8:0] s, input logic [31:0] d);
        @(negedge mclk);
        cmd = {s, d};
        @(negedge mclk);
        cmd = '0;
    endtask
    task automatic rd(input logic fast, input logic [31:0] exp);
        exp_q.push_back(exp);
        issue(fast ? 9'h001 : 9'h002, 32'h0);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // Clock, monitor, watchdog
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        rd_d <= cmd.fast_vector_rd | cmd.normal_vector_rd;
        rd_f <= cmd.fast_vector_rd;
    end
    always @(negedge mclk) if (rd_d) begin
        chk(rd_f ? status.fast_vector_reg : status.normal_vector_reg, exp_q.pop_front(), "vec");
    end
    initial begin
        #40000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    // ==========
    // Tests
    initial begin
        resetn = 1'b0;
        src_in = '0;
        src_in[5] = 1'b1;
        cfg = '0;
        cmd = '0;
        seed = 32'h175e;
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            cfg.vector_slot[i] = seed;
            cfg.prio[i] = 3'h5;
        end
        seed = lfsr(seed);
        cfg.spurious_vector_reg = seed;
        cfg.edge_mode = 32'h0000_0005;
        cfg.pol_high = '1;
        cfg.pol_high[5] = 1'b0;
        cfg.prio[5] = 3'h6;
        wt(4);
        resetn = 1'b1;
        chk({fast_req_n, normal_req_n}, 32'h3, "idle requests");
        chk(status.force_status_reg, 32'h0, "force reset");
        $display("test reset done");
        issue(C_EN, 32'h0000_001f);
        chk(status.mask_reg, 32'h0000_001f, "mask");
        src_in[0] = 1'b1;
        wt(4);
        src_in[0] = 1'b0;
        chk(fast_req_n, 1'b0, "fast edge");
        cfg.general_mask_bit = 1'b1;
        wt(1);
        chk({fast_req_n, wake_up}, 32'h3, "general mask");
        cfg.general_mask_bit = 1'b0;
        rd(1'b1, cfg.vector_slot[0]);
        chk({fast_req_n, status.pending_reg[0]}, 32'h2, "edge auto clear");
        cfg.edge_mode[0] = 1'b0;
        src_in[0] = 1'b1;
        wt(3);
        rd(1'b1, cfg.vector_slot[0]);
        chk(fast_req_n, 1'b0, "level kept");
        src_in[0] = 1'b0;
        wt(3);
        chk(fast_req_n, 1'b1, "level released");
        $display("test fast source done");
        issue(C_FEN, 32'h0000_0007);
        chk(status.force_status_reg, 32'h0000_0006, "force status");
        src_in[1] = 1'b1;
        wt(3);
        chk({fast_req_n, normal_req_n}, 32'h1, "forced level");
        chk(status.pending_reg[0], 1'b0, "src0 pending");
        src_in[2] = 1'b1;
        wt(1);
        src_in[2] = 1'b0;
        wt(3);
        rd(1'b1, cfg.vector_slot[0]);
        chk(status.pending_reg[2], 1'b1, "no auto clear");
        rd(1'b0, cfg.spurious_vector_reg);
        chk(status.pending_reg[2], 1'b1, "normal read kept");
        issue(C_CLR, 32'h0000_0004);
        src_in[1] = 1'b0;
        wt(3);
        chk({fast_req_n, status.pending_reg[2]}, 32'h2, "cleared");
        src_in[0] = 1'b1;
        wt(3);
        chk(fast_req_n, 1'b0, "src0 while forcing");
        src_in[0] = 1'b0;
        issue(C_FDIS, 32'h0000_0006);
        chk(status.force_status_reg, 32'h0, "force off");
        $display("test forcing done");
        src_in[3] = 1'b1;
        wt(3);
        rd(1'b0, cfg.vector_slot[3]);
        chk({status.current_irq_status, normal_req_n}, 32'h7, "normal ack");
        issue(C_NWR, 32'h0);
        chk(status.current_irq_status, 32'h3, "write no effect");
        src_in[3] = 1'b0;
        issue(C_EOI, 32'h0);
        $display("test normal done");
        cfg.debug_protect_bit = 1'b1;
        src_in[4] = 1'b1;
        wt(3);
        rd(1'b0, cfg.vector_slot[4]);
        rd(1'b0, cfg.vector_slot[4]);
        chk({status.current_irq_status, normal_req_n}, 32'h0, "protect read");
        issue(C_NWR, 32'h0);
        chk({status.current_irq_status, normal_req_n}, 32'h9, "protect write");
        src_in[4] = 1'b0;
        issue(C_EOI, 32'h0);
        cfg.debug_protect_bit = 1'b0;
        issue(C_EN, 32'h0000_0020);
        src_in[5] = 1'b0;
        wt(3);
        rd(1'b0, cfg.vector_slot[5]);
        chk({status.current_irq_status, normal_req_n}, 32'hb, "low level ack");
        src_in[5] = 1'b1;
        issue(C_EOI, 32'h0);
        chk(status.current_irq_status, 32'h0, "low level eoi");
        chk({31'h0, fast_seen != 0 && normal_seen != 0}, 32'h1, "core saw requests");
        $display("test protect done");
        end_sim();
    end
endmodule
